// ### pkg/smrbo_params.svh
// Purpose: Constants shared by both ends of the mode-register link.
// Assumes: A 50 MHz pclk on both ends.
// Notes:   Times are in ns; cycle counts derive from them.
`ifndef SMRBO_PARAMS_SVH
`define SMRBO_PARAMS_SVH
`define SMRBO_PCLK_NS        20
`define SMRBO_MA_INFO        8'h00
`define SMRBO_MA_FEAT        8'h01
`define SMRBO_MA_CAL         8'h0a
`define SMRBO_CAL_INIT_OP    8'hff
`define SMRBO_FEAT_RESET     8'h22
`define SMRBO_BL_POS         0
`define SMRBO_BT_POS         3
`define SMRBO_WC_POS         4
`define SMRBO_NWR_POS        5
`define SMRBO_BL4            3'h2
`define SMRBO_BL8            3'h3
`define SMRBO_BL16           3'h4
`define SMRBO_NWR_OFS        4'h2
`define SMRBO_RZQ_SUPPORTED  1'b1
`define SMRBO_DEV_NVM        1'b0
`define SMRBO_RZQ_NONE       2'h0
`define SMRBO_RZQ_SUPPLY     2'h1
`define SMRBO_RZQ_GROUND     2'h2
`define SMRBO_AUTO_INIT_NS   2000
`define SMRBO_CAL_NS         1000
`define SMRBO_AUTO_INIT_CYC  ((`SMRBO_AUTO_INIT_NS + `SMRBO_PCLK_NS - 1) / `SMRBO_PCLK_NS)
`define SMRBO_CAL_CYC        ((`SMRBO_CAL_NS + `SMRBO_PCLK_NS - 1) / `SMRBO_PCLK_NS)
`define SMRBO_CK_HALF        4'h4
`define SMRBO_REG_CMD        12'h000
`define SMRBO_REG_STAT       12'h004
`define SMRBO_CMD_RD_POS     16
`define SMRBO_CMD_MA_POS     8
`define SMRBO_CMD_WD_POS     0
`endif

// ### pkg/smrbo_pkg.sv
// Purpose: Types shared by both ends of the mode-register link.
// Assumes: Nothing beyond the constants header.
// Notes:   Link command codes are left to the tool.
package smrbo_pkg;
   typedef enum logic [1:0] {SMRBO_NOP, SMRBO_MRW, SMRBO_MRR} smrbo_cmd_e;
   typedef enum logic [1:0] {SMRBO_IDLE, SMRBO_SEND, SMRBO_WAIT} smrbo_state_e;
   typedef logic [7:0] smrbo_byte_t;
endpackage

// ### pkg/smrbo_link_if.sv
// Purpose: Mode-register command link between controller and device.
// Assumes: The controller makes ck from pclk; the device samples it with pclk.
// Notes:   Command fields change only while ck is low.
`timescale 1ns/1ps
interface smrbo_link_if;
   import smrbo_pkg::*;
   logic        ck;
   smrbo_cmd_e  cmd;
   smrbo_byte_t addr;
   smrbo_byte_t wdata;
   smrbo_byte_t rdata;
   logic        rtog;
   modport ctrl (output ck, output cmd, output addr, output wdata, input rdata, input rtog);
   modport dev  (input ck, input cmd, input addr, input wdata, output rdata, output rtog);
endinterface

// ### rtl/smrbo_device.sv
// Purpose: Device end: info and feature mode registers, burst order, recovery.
// Assumes: Link inputs are asynchronous to pclk and stable around ck rise.
// Notes:   Commands are taken at synchronised ck rising edges.
`timescale 1ns/1ps
`include "smrbo_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// [RQ1] Feature register at address 01h, write-only.
// [RQ2] Burst length codes 010, 011, 100.
// [RQ3] Type bit 3 interleave, bit 4 no-wrap.
// [RQ4] Recovery codes 001..110 give 3..8 cycles.
// [RQ5] Auto-precharge write starts precharge after recovery.
// [RQ6] Controller programs recovery rounded up.
// [RQ7] Four-beat wrap and no-wrap orders.
// [RQ8] Eight-beat sequential wraps modulo eight.
// [RQ9] Eight-beat interleave is index xor start.
// [RQ10] Controller never uses no-wrap with eight beats.
// [RQ11] Info bit 0 init busy, bit 1 nonvolatile.
// [RQ12] Info bit 2 reads zero.
// [RQ13] Info bits 4:3 report resistor self-test.
// [RQ14] Self-test field updates when calibration completes.
// [RQ15] Pin tied to supply reports 01.
// [RQ16] Results 01/10 force factory trim, ignore calibration.
// [RQ17] Result 11 only means resistor attached.
// [RQ18] Registers reached by read and write commands.
// [RQ19] Writes to info register change nothing.
// [RQ20] Info register at address 00h.
// [RQ21] Reserved bits written and read as zero.
// [RQ22] Controller polls init status before operation.
// [RQ23] Feature register resets to its defaults.
module smrbo_device
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   smrbo_link_if.dev                link,
   input  wire logic [1:0]          calib_sense,
   input  wire logic                burst_start,
   input  wire logic [3:0]          start_col,
   input  wire logic                wr_ap_end,
   output logic      [3:0]          beat_col,
   output logic                     beat_valid,
   output logic                     precharge_go,
   output logic                     factory_trim,
   output logic                     init_busy,
   output smrbo_pkg::smrbo_byte_t   feature
);
   import smrbo_pkg::*;

   typedef struct packed {
      logic        ck_s1;
      logic        ck_s2;
      logic        ck_s3;
      logic [1:0]  cmd_s1;
      logic [1:0]  cmd_s2;
      smrbo_byte_t addr_s1;
      smrbo_byte_t addr_s2;
      smrbo_byte_t wd_s1;
      smrbo_byte_t wd_s2;
      logic [1:0]  cal_s1;
      logic [1:0]  cal_s2;
      smrbo_byte_t feat;
      logic        init_busy;
      logic [7:0]  init_cnt;
      logic [1:0]  calib_resistor_test_info;
      logic        cal_busy;
      logic [7:0]  cal_cnt;
      logic        factory_trim;
      smrbo_byte_t rdata;
      logic        rtog;
      logic        beat_on;
      logic [3:0]  beat_cnt;
      logic [3:0]  beat_base;
      logic [3:0]  beat_col;
      logic        beat_valid;
      logic        wr_on;
      logic [3:0]  wr_cnt;
      logic        precharge_go;
   } smrbo_dev_s;

   smrbo_dev_s r;
   smrbo_dev_s next_r;

   logic       ck_rise;
   logic [3:0] len_mask;
   logic [3:0] seq_col;
   logic [3:0] col_now;
   logic       cmd_mrw;
   logic       cmd_mrr;

   ////////////////////////////////////////////////////////////////////////////
   // Decode of the stored feature fields and the link strobe.
   always_comb
   begin
      ck_rise = r.ck_s2 & ~r.ck_s3;
      cmd_mrw = ck_rise && (smrbo_cmd_e'(r.cmd_s2) == SMRBO_MRW);
      cmd_mrr = ck_rise && (smrbo_cmd_e'(r.cmd_s2) == SMRBO_MRR);
      // Unprogrammed length codes fall back to four beats so order stays defined.
      unique case (r.feat[`SMRBO_BL_POS +: 3])
         `SMRBO_BL8:  len_mask = 4'h7; // RQ2
         `SMRBO_BL16: len_mask = 4'hf; // RQ2
         default:     len_mask = 4'h3; // RQ2
      endcase
      seq_col = ((r.beat_base + r.beat_cnt) & len_mask) | (r.beat_base & ~len_mask);
      if (r.feat[`SMRBO_WC_POS]) // RQ3
         col_now = r.beat_base + r.beat_cnt; // RQ7
      else if (r.feat[`SMRBO_BT_POS] && len_mask != 4'h3) // RQ3
         col_now = r.beat_base ^ r.beat_cnt; // RQ9
      else
         col_now = seq_col; // RQ7 RQ8
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic for the whole device end.
   always_comb
   begin
      next_r = r;
      next_r.ck_s1 = link.ck;
      next_r.ck_s2 = r.ck_s1;
      next_r.ck_s3 = r.ck_s2;
      next_r.cmd_s1 = link.cmd;
      next_r.cmd_s2 = r.cmd_s1;
      next_r.addr_s1 = link.addr;
      next_r.addr_s2 = r.addr_s1;
      next_r.wd_s1 = link.wdata;
      next_r.wd_s2 = r.wd_s1;
      next_r.cal_s1 = calib_sense;
      next_r.cal_s2 = r.cal_s1;
      next_r.precharge_go = 1'b0;

      // Auto-initialisation runs from reset; the controller must poll it.
      if (r.init_busy)
      begin
         next_r.init_cnt = r.init_cnt - 8'h01;
         if (r.init_cnt == 8'h01)
            next_r.init_busy = 1'b0; // RQ11
      end

      // Writes land only in the feature register; the info register ignores them.
      if (cmd_mrw)
      begin
         if (r.addr_s2 == `SMRBO_MA_FEAT)
            next_r.feat = r.wd_s2; // RQ1 RQ18 RQ19
         // After a fault result the device keeps factory trim and drops calibration.
         if (r.addr_s2 == `SMRBO_MA_CAL && r.wd_s2 == `SMRBO_CAL_INIT_OP
             && !r.factory_trim && !r.cal_busy)
         begin
            next_r.cal_busy = 1'b1; // RQ16
            next_r.cal_cnt = 8'(`SMRBO_CAL_CYC);
         end
      end

      // The info register shows live state; reserved bits and other maps read zero.
      if (cmd_mrr)
      begin
         next_r.rtog = ~r.rtog; // RQ18
         if (r.addr_s2 == `SMRBO_MA_INFO)
            next_r.rdata = {3'h0, r.calib_resistor_test_info, 1'b0, `SMRBO_DEV_NVM, r.init_busy}; // RQ11 RQ12 RQ13 RQ20 RQ21
         else
            next_r.rdata = 8'h00;
      end

      // Self-test result is taken from the pin sense at calibration end.
      // A code of 11 only says a resistor is present, not that it is in tolerance.
      if (r.cal_busy)
      begin
         next_r.cal_cnt = r.cal_cnt - 8'h01;
         if (r.cal_cnt == 8'h01)
         begin
            next_r.cal_busy = 1'b0;
            if (`SMRBO_RZQ_SUPPORTED)
            begin
               next_r.calib_resistor_test_info = r.cal_s2; // RQ14 RQ15 RQ17
               if (r.cal_s2 == `SMRBO_RZQ_SUPPLY || r.cal_s2 == `SMRBO_RZQ_GROUND)
                  next_r.factory_trim = 1'b1; // RQ16
            end
         end
      end

      // Burst column sequencer, one column per pclk.
      next_r.beat_valid = r.beat_on;
      next_r.beat_col = col_now;
      if (r.beat_on)
      begin
         next_r.beat_cnt = r.beat_cnt + 4'h1;
         if (r.beat_cnt == len_mask)
            next_r.beat_on = 1'b0;
      end
      if (burst_start)
      begin
         next_r.beat_on = 1'b1;
         next_r.beat_cnt = 4'h0;
         next_r.beat_base = {start_col[3:1], 1'b0}; // RQ7
      end

      // Recovery counts link clocks from the last write beat to precharge start.
      if (r.wr_on && ck_rise)
      begin
         next_r.wr_cnt = r.wr_cnt - 4'h1;
         if (r.wr_cnt == 4'h1)
         begin
            next_r.wr_on = 1'b0;
            next_r.precharge_go = 1'b1; // RQ5
         end
      end
      if (wr_ap_end)
      begin
         next_r.wr_on = 1'b1;
         next_r.wr_cnt = {1'b0, r.feat[`SMRBO_NWR_POS +: 3]} + `SMRBO_NWR_OFS; // RQ4 RQ5
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; reset loads the feature defaults and starts initialisation.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '0;
         r.feat <= `SMRBO_FEAT_RESET; // RQ23
         r.init_busy <= 1'b1;
         r.init_cnt <= 8'(`SMRBO_AUTO_INIT_CYC);
      end
      else
         r <= next_r;
   end

   assign link.rdata = r.rdata;
   assign link.rtog = r.rtog;
   assign beat_col = r.beat_col;
   assign beat_valid = r.beat_valid;
   assign precharge_go = r.precharge_go;
   assign factory_trim = r.factory_trim;
   assign init_busy = r.init_busy;
   assign feature = r.feat;
endmodule

// ### rtl/smrbo_controller.sv
// Purpose: Controller end: APB-driven mode-register reads and writes.
// Assumes: Software writes only legal feature codes.
// Notes:   ck is pclk divided by eight; commands change on ck falling.
`timescale 1ns/1ps
`include "smrbo_params.svh"
module smrbo_controller
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   smrbo_link_if.ctrl         link
);
   import smrbo_pkg::*;

   typedef struct packed {
      logic         ck;
      logic [3:0]   div;
      smrbo_cmd_e   cmd;
      smrbo_byte_t  addr;
      smrbo_byte_t  wdata;
      smrbo_state_e state;
      logic         pend;
      logic         pend_rd;
      smrbo_byte_t  pend_addr;
      smrbo_byte_t  pend_wd;
      logic         rt_s1;
      logic         rt_s2;
      logic         rt_s3;
      smrbo_byte_t  rd_s1;
      smrbo_byte_t  rd_s2;
      smrbo_byte_t  rd_last;
      logic         pready;
      logic [31:0]  prdata;
   } smrbo_ctl_s;

   smrbo_ctl_s r;
   smrbo_ctl_s next_r;
   logic       ck_fall;
   logic       acc;

   ////////////////////////////////////////////////////////////////////////////
   // Next state: clock divider, command sequencer, APB slave.
   always_comb
   begin
      next_r = r;
      acc = psel && penable && r.pready;
      ck_fall = r.ck && (r.div == `SMRBO_CK_HALF - 4'h1);
      next_r.rt_s1 = link.rtog;
      next_r.rt_s2 = r.rt_s1;
      next_r.rt_s3 = r.rt_s2;
      next_r.rd_s1 = link.rdata;
      next_r.rd_s2 = r.rd_s1;

      if (r.div == `SMRBO_CK_HALF - 4'h1)
      begin
         next_r.div = 4'h0;
         next_r.ck = ~r.ck;
      end
      else
         next_r.div = r.div + 4'h1;

      // Commands stand for one full ck period, launched while ck goes low.
      unique case (r.state)
         SMRBO_IDLE:
            if (ck_fall && r.pend)
            begin
               next_r.cmd = r.pend_rd ? SMRBO_MRR : SMRBO_MRW; // RQ18
               next_r.addr = r.pend_addr;
               next_r.wdata = r.pend_wd;
               next_r.state = SMRBO_SEND;
            end
         SMRBO_SEND:
            if (ck_fall)
            begin
               next_r.cmd = SMRBO_NOP;
               next_r.state = r.pend_rd ? SMRBO_WAIT : SMRBO_IDLE;
               next_r.pend = r.pend_rd;
            end
         SMRBO_WAIT:
            if (r.rt_s2 != r.rt_s3)
            begin
               next_r.rd_last = r.rd_s2;
               next_r.pend = 1'b0;
               next_r.state = SMRBO_IDLE;
            end
      endcase

      // Software must keep reserved bits zero and poll init status itself.
      next_r.pready = psel && !penable;
      if (acc && pwrite && paddr == `SMRBO_REG_CMD && !r.pend)
      begin
         next_r.pend = 1'b1; // RQ2 RQ4 RQ6 RQ10 RQ21 RQ22
         next_r.pend_rd = pwdata[`SMRBO_CMD_RD_POS];
         next_r.pend_addr = pwdata[`SMRBO_CMD_MA_POS +: 8];
         next_r.pend_wd = pwdata[`SMRBO_CMD_WD_POS +: 8];
      end
      if (psel && !penable && !pwrite)
      begin
         if (paddr == `SMRBO_REG_STAT)
            next_r.prdata = {16'h0000, r.rd_last, 7'h00, r.pend};
         else if (paddr == `SMRBO_REG_CMD)
            next_r.prdata = {15'h0000, r.pend_rd, r.pend_addr, r.pend_wd};
         else
            next_r.prdata = 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         r <= '0;
      else
         r <= next_r;
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = 1'b0;
   assign link.ck = r.ck;
   assign link.cmd = r.cmd;
   assign link.addr = r.addr;
   assign link.wdata = r.wdata;
endmodule

// ### verification/smrbo_assertions.sv
// Purpose: Link-side checker for the mode-register command link.
// Assumes: ck is pclk divided by eight and driven by the controller.
// Notes:   Sees only link signals, so device state is judged from answers.
`timescale 1ns/1ps
module smrbo_assertions
(
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   ck,
   input wire smrbo_pkg::smrbo_cmd_e  cmd,
   input wire smrbo_pkg::smrbo_byte_t addr,
   input wire smrbo_pkg::smrbo_byte_t wdata,
   input wire smrbo_pkg::smrbo_byte_t rdata,
   input wire logic                   rtog
);
   import smrbo_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Command fields move only while ck is low, so the device never samples a change.
   chk_cmd_ck_low: assert property ($changed(cmd) |-> !ck)
      else $error("cmd changed while ck high");
   chk_addr_ck_low: assert property ($changed(addr) || $changed(wdata) |-> !ck)
      else $error("addr or wdata changed while ck high");
   chk_ck_high_four: assert property ($rose(ck) |-> ck[*4] ##1 !ck)
      else $error("ck high phase is not four cycles");
   // Read answers: the data only moves with a toggle, and only after a read.
   chk_rdata_stands: assert property ($changed(rdata) |-> $changed(rtog))
      else $error("rdata moved without rtog");
   chk_read_answer: assert property ($changed(rtog) |-> $past(cmd, 4) == SMRBO_MRR)
      else $error("rtog moved without a read command");
   chk_read_bound: assert property ($rose(ck) && cmd == SMRBO_MRR |-> ##[1:8] $changed(rtog))
      else $error("read answer late");
   chk_write_silent: assert property ($rose(ck) && cmd == SMRBO_MRW |-> $stable(rtog)[*8])
      else $error("write produced a read answer");
   // Fixed fields of the information register and zero reads elsewhere.
   chk_info_rsvd: assert property ($changed(rtog) |-> rdata[7:5] == 3'h0)
      else $error("reserved bits not zero");
   chk_info_dnv: assert property ($changed(rtog) |-> rdata[2] == 1'b0)
      else $error("invalid data bit not zero");
   chk_info_kind: assert property ($changed(rtog) |-> rdata[1] == 1'b0)
      else $error("device kind bit not zero");
   chk_other_zero: assert property ($changed(rtog) && $past(addr, 4) != 8'h00 |-> rdata == 8'h00)
      else $error("read of other register not zero");
   cover property ($rose(ck) && cmd == SMRBO_MRW && addr == 8'h0a);
   cover property ($rose(ck) && cmd == SMRBO_MRW && addr == 8'h01);
   cover property ($changed(rtog) && rdata[4:3] == 2'h1);
endmodule

// ### verification/sdram_mode_reg_burst_order_test.sv
// Purpose: Self-checking bench joining controller and device over the link.
// Assumes: ck runs free from the controller divider.
// Notes:   Drivers queue expected results; monitors compare them.
`timescale 1ns/1ps
`include "smrbo_params.svh"
module sdram_mode_reg_burst_order_test;
   import smrbo_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        burst_start, wr_ap_end, beat_valid, precharge_go, factory_trim, init_busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  calib_sense;
   logic [3:0]  start_col, beat_col, col;
   logic [2:0]  bl, write_recovery_cycles;
   logic        bt, wc;
   logic [7:0]  d;
   smrbo_byte_t feature;
   int          fail_count, n_tests, n, w;
   logic [31:0] exp_q[$];
   logic [3:0]  beat_q[$];

   smrbo_link_if i_smrbo_link_if ();
   smrbo_controller i_smrbo_controller (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .link(i_smrbo_link_if.ctrl));
   smrbo_device i_smrbo_device (.pclk, .presetn, .link(i_smrbo_link_if.dev), .calib_sense,
      .burst_start, .start_col, .wr_ap_end, .beat_col, .beat_valid, .precharge_go,
      .factory_trim, .init_busy, .feature);
   smrbo_assertions i_smrbo_assertions (.pclk, .presetn, .ck(i_smrbo_link_if.ck),
      .cmd(i_smrbo_link_if.cmd), .addr(i_smrbo_link_if.addr), .wdata(i_smrbo_link_if.wdata),
      .rdata(i_smrbo_link_if.rdata), .rtog(i_smrbo_link_if.rtog));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock at 50 MHz.
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done();
      if (fail_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // One APB transfer; entered just after an edge, holds until pready is sampled.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait; the slave decides when it answers.
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Polls the status word until the link command has finished.
   task automatic wait_idle();
      rd = 32'h1;
      while (rd[0] !== 1'b0)
         apb(1'b0, 12'h004, 32'h0);
   endtask

   task automatic mrr(input logic [7:0] a, input logic [7:0] e);
      apb(1'b1, 12'h000, {15'h0, 1'b1, a, 8'h00});
      wait_idle();
      exp_q.push_back({16'h0, e, 8'h00});
      apb(1'b0, 12'h004, 32'h0);
   endtask

   task automatic mrw(input logic [7:0] a, input logic [7:0] dat);
      apb(1'b1, 12'h000, {16'h0, a, dat});
      wait_idle();
   endtask

   // Column of beat i; except in no-wrap mode, high column bits outside the burst stay as given.
   function automatic logic [3:0] beat(input logic [3:0] b, input logic [3:0] i);
      logic [3:0] m;
      m = (bl == 3'h2) ? 4'h3 : (bl == 3'h3) ? 4'h7 : 4'hf;
      if (wc)
         return b + i;
      if (bt && bl != 3'h2)
         return b ^ i;
      return (b & ~m) | ((b + i) & m);
   endfunction

   // Monitors take the oldest queued note whenever a result shows.
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
         check("prdata", prdata, exp_q.pop_front());
      if (psel && penable && pready === 1'b1)
         check("pslverr", pslverr, 32'h0);
      if (beat_valid === 1'b1)
         check("beat_col", beat_col, beat_q.size() > 0 ? beat_q.pop_front() : 4'hx);
   end

   initial
   begin
      {psel, penable, pwrite, burst_start, wr_ap_end, presetn} = 6'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      start_col = 4'h0;
      calib_sense = 2'h3;
      fail_count = 0;
      n_tests = 0;
      void'($urandom(1749));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("feature", feature, 32'h22);
      check("init_busy", init_busy, 32'h1);
      mrr(8'h00, 8'h01);
      while (init_busy !== 1'b0)
         @(posedge pclk);
      mrr(8'h00, 8'h00);
      mrw(8'h00, 8'hff);
      mrr(8'h00, 8'h00);
      check("feature", feature, 32'h22);
      mrr(8'h01, 8'h00);
      exp_q.push_back(32'h0001_0100);
      apb(1'b0, 12'h000, 32'h0);
      exp_q.push_back(32'h0);
      apb(1'b0, 12'h010, 32'h0);
      // Resistor sensed, then supply tie, then ground tie that must be ignored.
      for (int k = 0; k < 3; k++)
      begin
         calib_sense <= (k == 0) ? 2'h3 : 2'(k);
         mrw(8'h0a, 8'hff);
         repeat (80) @(posedge pclk);
         mrr(8'h00, (k == 0) ? 8'h18 : 8'h08);
         check("factory_trim", factory_trim, k != 0);
      end
      check("link_rdata", i_smrbo_link_if.rdata, 32'h08);
      // Every length, type and wrap except no-wrap above four beats and sixteen-beat interleave, with random start and recovery.
      for (int c = 0; c < 12; c++)
      begin
         bl = 3'(2 + c / 4);
         bt = c[0];
         wc = c[1];
         if (bl != 3'h2 && (wc || (bl == 3'h4 && bt)))
            continue;
         write_recovery_cycles = 3'($urandom_range(6, 1));
         col = 4'($urandom) & 4'he;
         d = {write_recovery_cycles, wc, bt, bl};
         mrw(8'h01, d);
         check("feature", feature, d);
         burst_start <= 1'b1;
         start_col <= col | 4'($urandom_range(1, 0));
         for (int i = 0; i < (4 << (bl - 3'h2)); i++)
            beat_q.push_back(beat(col, 4'(i)));
         @(posedge pclk);
         burst_start <= 1'b0;
         repeat (20) @(posedge pclk);
         check("beats_left", beat_q.size(), 0);
         wr_ap_end <= 1'b1;
         @(posedge pclk);
         wr_ap_end <= 1'b0;
         n = 0;
         w = 8 * (write_recovery_cycles + 2);
         while (precharge_go !== 1'b1 && n < 200)
         begin
            @(posedge pclk);
            n++;
         end
         check("precharge_wait", n >= w - 6 && n <= w + 2, 1);
      end
      test_done();
   end

   // Watchdog: the sequence needs well under a tenth of this span.
   initial
   begin
      #400us;
      fail_count++;
      test_done();
   end
endmodule
